/* File: phy_bus_event_interrupt.sv */
// Bus event interrupt sources: edge enables, live status, event latch.
// Assumes register accesses arrive already decoded from the link
// interface on i_clock, and that low-power entry is a same-clock level.
//
// Behaviour
// - Enabled rising source edge raises interrupt, command
// - Enabled falling source edge raises interrupt, command
// - Enables reset to ones, reserved bits zero
// - Rising enables: read three addresses, write/set/clear
// - Falling enables: read three addresses, write/set/clear
// - Rising enable bit order: id down to detach
// - Status register shows live source values
// - Status bits follow their detector circuits
// - Unmasked transition sets its latch bit
// - Reading latch register clears all bits but those set by a same-cycle event
// - Low-power entry clears latch but keeps same-cycle events; resets to zero
module phy_bus_event_interrupt
	import phy_event_pkg::*;
(
	input  logic                  i_clock,
	input  logic                  i_rst,
	input  logic                  i_id_pin_grounded,
	input  logic                  i_session_ended,
	input  logic                  i_session_ok,
	input  logic                  i_bus_power_good,
	input  logic                  i_far_end_detached,
	input  logic                  i_low_power,
	input  logic                  i_reg_write,
	input  logic                  i_reg_read,
	input  logic [ADDR_WIDTH-1:0] i_reg_addr,
	input  logic [DATA_WIDTH-1:0] i_reg_wdata,
	output logic [DATA_WIDTH-1:0] o_reg_rdata,
	output logic                  o_reg_rvalid,
	output logic                  o_interrupt,
	output logic                  o_rxcmd_valid,
	output logic [SOURCE_COUNT-1:0] o_rxcmd_status
);

	// ****************************************************************
	// Address decoding
	// ****************************************************************
	function automatic reg_op_type decode_op
	(
		input logic [ADDR_WIDTH-1:0] addr,
		input logic [ADDR_WIDTH-1:0] base
	);
		if (addr == base)
			return OP_WRITE;
		else if (addr == base + 6'h01)
			return OP_SET;
		else if (addr == base + 6'h02)
			return OP_CLEAR;
		else
			return OP_NONE;
	endfunction : decode_op

	function automatic logic [SOURCE_COUNT-1:0] apply_op
	(
		input reg_op_type              op,
		input logic [SOURCE_COUNT-1:0] old,
		input logic [SOURCE_COUNT-1:0] data
	);
		case (op)
			OP_WRITE: return data;
			OP_SET:   return old | data;
			OP_CLEAR: return old & ~data;
			default:  return old;
		endcase
	endfunction : apply_op

	source_event_if #(.WIDTH(SOURCE_COUNT)) evt ();

	logic [SOURCE_COUNT-1:0] source_raw;
	logic [SOURCE_COUNT-1:0] wdata_src;
	reg_op_type              rise_op;
	reg_op_type              fall_op;
	logic                    rise_hit;
	logic                    fall_hit;
	logic                    status_hit;
	logic                    latch_hit;
	logic                    latch_read;
	logic [SOURCE_COUNT-1:0] events;
	logic                    any_event;
	logic [SOURCE_COUNT-1:0] read_src;

	// Bit order shared by every register of the block
	assign source_raw[ID_PIN_BIT]        = i_id_pin_grounded;
	assign source_raw[SESSION_ENDED_BIT] = i_session_ended;
	assign source_raw[SESSION_OK_BIT]    = i_session_ok;
	assign source_raw[BUS_POWER_BIT]     = i_bus_power_good;
	assign source_raw[DETACH_BIT]        = i_far_end_detached;

	assign wdata_src  = i_reg_wdata[SOURCE_COUNT-1:0];
	assign rise_op    = i_reg_write ? decode_op(i_reg_addr, RISE_EN_WRITE_ADDR)
		: OP_NONE;
	assign fall_op    = i_reg_write ? decode_op(i_reg_addr, FALL_EN_WRITE_ADDR)
		: OP_NONE;
	assign rise_hit   = decode_op(i_reg_addr, RISE_EN_WRITE_ADDR) != OP_NONE;
	assign fall_hit   = decode_op(i_reg_addr, FALL_EN_WRITE_ADDR) != OP_NONE;
	assign status_hit = i_reg_addr == STATUS_ADDR;
	assign latch_hit  = i_reg_addr == LATCH_ADDR;
	assign latch_read = i_reg_read && latch_hit;

	// ****************************************************************
	// Source synchroniser and edge finder
	// ****************************************************************
	source_edge_detect #(.WIDTH(SOURCE_COUNT)) u_edges
	(
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_source (source_raw),
		.evt      (evt.detector)
	);

	assign events    = evt.rise_event | evt.fall_event;
	assign any_event = |events;

	// ****************************************************************
	// Edge enable registers
	// ****************************************************************
	logic [SOURCE_COUNT-1:0] rise_en_q;
	logic [SOURCE_COUNT-1:0] rise_en_d;
	logic [SOURCE_COUNT-1:0] fall_en_q;
	logic [SOURCE_COUNT-1:0] fall_en_d;

	assign rise_en_d = apply_op(rise_op, rise_en_q, wdata_src);
	assign fall_en_d = apply_op(fall_op, fall_en_q, wdata_src);
	assign evt.rise_enable = rise_en_q;
	assign evt.fall_enable = fall_en_q;

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			rise_en_q <= ENABLE_RESET;
			fall_en_q <= ENABLE_RESET;
		end
		else
		begin
			rise_en_q <= rise_en_d;
			fall_en_q <= fall_en_d;
		end
	end

	// ****************************************************************
	// Event latch
	// ****************************************************************
	logic                    low_power_q;
	logic                    low_power_entry;
	logic [SOURCE_COUNT-1:0] latch_q;
	logic [SOURCE_COUNT-1:0] latch_d;
	logic                    latch_clear;

	assign low_power_entry = i_low_power && !low_power_q;
	assign latch_clear     = latch_read || low_power_entry;
	// A new event wins over a clear in the same cycle
	assign latch_d = (latch_clear ? LATCH_RESET : latch_q) | events;

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			latch_q     <= LATCH_RESET;
			low_power_q <= 1'b0;
		end
		else
		begin
			latch_q     <= latch_d;
			low_power_q <= i_low_power;
		end
	end

	// ****************************************************************
	// Read data and event outputs
	// ****************************************************************
	logic [DATA_WIDTH-1:0] rdata_q;
	logic                  rvalid_q;
	logic                  irq_q;
	logic                  rxcmd_q;
	logic [SOURCE_COUNT-1:0] rxcmd_status_q;

	assign read_src = rise_hit   ? rise_en_q
		: fall_hit   ? fall_en_q
		: status_hit ? evt.level
		: latch_hit  ? latch_q
		: LATCH_RESET;

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			rdata_q        <= {RESERVED_VAL, LATCH_RESET};
			rvalid_q       <= 1'b0;
			irq_q          <= 1'b0;
			rxcmd_q        <= 1'b0;
			rxcmd_status_q <= LEVEL_RESET;
		end
		else
		begin
			if (i_reg_read)
				rdata_q <= {RESERVED_VAL, read_src};
			rvalid_q <= i_reg_read;
			irq_q    <= any_event;
			rxcmd_q  <= any_event;
			if (any_event)
				rxcmd_status_q <= evt.level;
		end
	end

	assign o_reg_rdata    = rdata_q;
	assign o_reg_rvalid   = rvalid_q;
	assign o_interrupt    = irq_q;
	assign o_rxcmd_valid  = rxcmd_q;
	assign o_rxcmd_status = rxcmd_status_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	sequence s_rise_seen;
		evt.level[ID_PIN_BIT] && !$past(evt.level[ID_PIN_BIT]);
	endsequence

	sequence s_fall_seen;
		!evt.level[SESSION_OK_BIT] && $past(evt.level[SESSION_OK_BIT]);
	endsequence

	sequence s_sources_steady;
		$stable(source_raw)[*6];
	endsequence

	property p_rise_irq;
		s_rise_seen and rise_en_q[ID_PIN_BIT]
			|=> o_interrupt && o_rxcmd_valid;
	endproperty
	a_rise_irq : assert property (p_rise_irq)
		else $error("enabled rising edge gave no interrupt");

	property p_fall_irq;
		s_fall_seen and fall_en_q[SESSION_OK_BIT]
			|=> o_interrupt && o_rxcmd_valid;
	endproperty
	a_fall_irq : assert property (p_fall_irq)
		else $error("enabled falling edge gave no interrupt");

	property p_quiet_when_masked;
		$stable(evt.level) || ((rise_en_q == '0) && (fall_en_q == '0))
			|=> !o_interrupt;
	endproperty
	a_quiet_when_masked : assert property (p_quiet_when_masked)
		else $error("interrupt without an enabled edge");

	property p_reset_values;
		$fell(i_rst) |-> rise_en_q == ENABLE_RESET
			&& fall_en_q == ENABLE_RESET && latch_q == LATCH_RESET;
	endproperty
	a_reset_values : assert property (p_reset_values)
		else $error("enable or latch reset value wrong");

	property p_rise_set;
		i_reg_write && i_reg_addr == RISE_EN_SET_ADDR
			|=> rise_en_q == ($past(rise_en_q) | $past(wdata_src));
	endproperty
	a_rise_set : assert property (p_rise_set)
		else $error("rising enable set did not OR the byte");

	property p_fall_clear;
		i_reg_write && i_reg_addr == FALL_EN_CLEAR_ADDR
			|=> fall_en_q == ($past(fall_en_q) & ~$past(wdata_src));
	endproperty
	a_fall_clear : assert property (p_fall_clear)
		else $error("falling enable clear did not clear bits");

	property p_write_replace;
		i_reg_write && i_reg_addr == RISE_EN_WRITE_ADDR
			|=> rise_en_q == $past(wdata_src);
	endproperty
	a_write_replace : assert property (p_write_replace)
		else $error("plain write did not replace enable byte");

	property p_alias_read;
		i_reg_read && !i_reg_write && i_reg_addr == FALL_EN_CLEAR_ADDR
			|=> o_reg_rvalid && o_reg_rdata == {RESERVED_VAL, fall_en_q};
	endproperty
	a_alias_read : assert property (p_alias_read)
		else $error("falling enable not readable at clear address");

	property p_status_read;
		i_reg_read && status_hit
			|=> o_reg_rdata == {RESERVED_VAL, $past(evt.level)};
	endproperty
	a_status_read : assert property (p_status_read)
		else $error("status read did not show live levels");

	property p_status_follows;
		s_sources_steady |-> evt.level == source_raw;
	endproperty
	a_status_follows : assert property (p_status_follows)
		else $error("status does not follow steady source");

	property p_latch_set;
		any_event |=> (latch_q & $past(events)) == $past(events);
	endproperty
	a_latch_set : assert property (p_latch_set)
		else $error("unmasked event not latched");

	property p_latch_read_clear;
		latch_read && !any_event |=> latch_q == LATCH_RESET;
	endproperty
	a_latch_read_clear : assert property (p_latch_read_clear)
		else $error("latch read did not clear latch");

	property p_low_power_clear;
		$rose(i_low_power) && !any_event |=> latch_q == LATCH_RESET;
	endproperty
	a_low_power_clear : assert property (p_low_power_clear)
		else $error("low-power entry did not clear latch");

	property p_latch_holds;
		!latch_clear && !any_event |=> latch_q == $past(latch_q);
	endproperty
	a_latch_holds : assert property (p_latch_holds)
		else $error("latch changed without cause");

	property p_reserved_zero;
		o_reg_rvalid |-> o_reg_rdata[DATA_WIDTH-1:SOURCE_COUNT] == RESERVED_VAL;
	endproperty
	a_reserved_zero : assert property (p_reserved_zero)
		else $error("reserved bits read nonzero");

	property p_rxcmd_snapshot;
		any_event |=> o_rxcmd_status == $past(evt.level);
	endproperty
	a_rxcmd_snapshot : assert property (p_rxcmd_snapshot)
		else $error("command byte status not captured");

endmodule : phy_bus_event_interrupt

/* File: phy_event_pkg.sv */
// Constants for the bus event interrupt source logic.
// Assumes 6-bit immediate register addresses and 8-bit register data.
package phy_event_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int SOURCE_COUNT = 5;
	localparam int ADDR_WIDTH   = 6;
	localparam int DATA_WIDTH   = 8;

	// ****************************************************************
	// Register addresses: write, set, clear for each enable; then status and latch
	// ****************************************************************
	localparam logic [5:0] RISE_EN_WRITE_ADDR = 6'h0d;
	localparam logic [5:0] RISE_EN_SET_ADDR   = 6'h0e;
	localparam logic [5:0] RISE_EN_CLEAR_ADDR = 6'h0f;
	localparam logic [5:0] FALL_EN_WRITE_ADDR = 6'h10;
	localparam logic [5:0] FALL_EN_SET_ADDR   = 6'h11;
	localparam logic [5:0] FALL_EN_CLEAR_ADDR = 6'h12;
	localparam logic [5:0] STATUS_ADDR        = 6'h13;
	localparam logic [5:0] LATCH_ADDR         = 6'h14;

	// ****************************************************************
	// Field positions, shared by all four registers
	// ****************************************************************
	localparam int DETACH_BIT        = 0;
	localparam int BUS_POWER_BIT     = 1;
	localparam int SESSION_OK_BIT    = 2;
	localparam int SESSION_ENDED_BIT = 3;
	localparam int ID_PIN_BIT        = 4;

	// ****************************************************************
	// Values after reset
	// ****************************************************************
	localparam logic [4:0] ENABLE_RESET = 5'h1f;
	localparam logic [4:0] LATCH_RESET  = 5'h00;
	localparam logic [4:0] LEVEL_RESET  = 5'h00;
	localparam logic [2:0] RESERVED_VAL = 3'h0;

	// ****************************************************************
	// Register access operations
	// ****************************************************************
	typedef enum logic [1:0]
	{
		OP_NONE  = 2'b00,
		OP_WRITE = 2'b01,
		OP_SET   = 2'b10,
		OP_CLEAR = 2'b11
	} reg_op_type;

endpackage : phy_event_pkg

/* File: source_event_if.sv */
// Carries source levels, edge enables and edge events between modules.
// Assumes both ends run on the same clock.
interface source_event_if #(parameter int WIDTH = 5);

	logic [WIDTH-1:0] rise_enable;
	logic [WIDTH-1:0] fall_enable;
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] rise_event;
	logic [WIDTH-1:0] fall_event;

	modport detector
	(
		input  rise_enable,
		input  fall_enable,
		output level,
		output rise_event,
		output fall_event
	);

	modport control
	(
		output rise_enable,
		output fall_enable,
		input  level,
		input  rise_event,
		input  fall_event
	);

endinterface : source_event_if

/* File: source_edge_detect.sv */
// Synchronises the analogue-derived source signals and finds edges.
// Assumes raw sources are asynchronous to i_clock.
module source_edge_detect
	import phy_event_pkg::*;
#(
	parameter int WIDTH = SOURCE_COUNT
)
(
	input  logic             i_clock,
	input  logic             i_rst,
	input  logic [WIDTH-1:0] i_source,
	source_event_if.detector evt
);

	// ****************************************************************
	// Three-stage synchroniser with agreement filter
	// ****************************************************************
	logic [WIDTH-1:0] sync1_q;
	logic [WIDTH-1:0] sync2_q;
	logic [WIDTH-1:0] sync3_q;
	logic [WIDTH-1:0] level_q;
	logic [WIDTH-1:0] level_d;
	logic [WIDTH-1:0] last_q;
	logic [WIDTH-1:0] agree;

	assign agree   = ~(sync2_q ^ sync3_q);
	assign level_d = (agree & sync3_q) | (~agree & level_q);

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			sync1_q <= LEVEL_RESET;
			sync2_q <= LEVEL_RESET;
			sync3_q <= LEVEL_RESET;
			level_q <= LEVEL_RESET;
			last_q  <= LEVEL_RESET;
		end
		else
		begin
			sync1_q <= i_source;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			level_q <= level_d;
			last_q  <= level_q;
		end
	end

	// ****************************************************************
	// Edge events against the previous cycle
	// ****************************************************************
	assign evt.level      = level_q;
	assign evt.rise_event = level_q & ~last_q & evt.rise_enable;
	assign evt.fall_event = ~level_q & last_q & evt.fall_enable;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	property p_one_cycle_event;
		(|evt.rise_event) |=> (evt.rise_event & $past(evt.rise_event)) == '0;
	endproperty
	a_one_cycle_event : assert property (p_one_cycle_event)
		else $error("rise event lasted more than one cycle");

endmodule : source_edge_detect

/* File: link_model.sv */
// Link controller model: issues single-byte register accesses.
// Assumes the device takes a strobe at a rising edge of i_clock and
// answers a read with a one-cycle valid pulse set on that same edge.
module link_model
	import phy_event_pkg::*;
(
	input  wire logic                  i_clock,
	input  wire logic [DATA_WIDTH-1:0] i_reg_rdata,
	input  wire logic                  i_reg_rvalid,
	output logic                       o_reg_write,
	output logic                       o_reg_read,
	output logic [ADDR_WIDTH-1:0]      o_reg_addr,
	output logic [DATA_WIDTH-1:0]      o_reg_wdata
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		o_reg_write = 1'b0;
		o_reg_read  = 1'b0;
		o_reg_addr  = 6'h00;
		o_reg_wdata = 8'h00;
	end

	// ****************************************************************
	// Accesses: held from just after one edge to just after the next
	// ****************************************************************
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge i_clock);
		#1;
		o_reg_write = 1'b1;
		o_reg_addr  = a;
		o_reg_wdata = d;
		@(posedge i_clock);
		#1;
		o_reg_write = 1'b0;
		o_reg_wdata = ~d;
	endtask : wr

	// Latch reads are only done when asked, never by polling
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge i_clock);
		#1;
		o_reg_read = 1'b1;
		o_reg_addr = a;
		@(posedge i_clock);
		#1;
		o_reg_read = 1'b0;
		// Answer stands for the cycle after the taking edge
		d = i_reg_rvalid ? i_reg_rdata : 8'hxx;
	endtask : rd
endmodule : link_model

/* File: phy_bus_event_interrupt_bench.sv */
// Self-checking bench for the bus event interrupt source logic.
// Assumes link_model drives the register strobes; sources set here.
module phy_bus_event_interrupt_bench;
	import phy_event_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed
	{
		logic [2:0] idx;
		logic       lvl;
		logic [4:0] ren;
		logic [4:0] fen;
		logic [1:0] pulses;
	} row_type;

	logic                  i_clock = 1'b0;
	logic                  i_rst   = 1'b1;
	logic [4:0]            src     = 5'h00;
	logic                  i_low_power = 1'b0;
	logic                  reg_write;
	logic                  reg_read;
	logic [ADDR_WIDTH-1:0] reg_addr;
	logic [DATA_WIDTH-1:0] reg_wdata;
	logic [DATA_WIDTH-1:0] o_reg_rdata;
	logic                  o_reg_rvalid;
	logic                  o_interrupt;
	logic                  o_rxcmd_valid;
	logic [4:0]            o_rxcmd_status;
	int                    failures   = 0;
	int                    n_compared = 0;
	int                    cycles     = 0;
	logic [7:0]            d;
	row_type               rows [10];

	always #5 i_clock = ~i_clock;

	phy_bus_event_interrupt dut
	(
		.i_clock           (i_clock),
		.i_rst             (i_rst),
		.i_id_pin_grounded (src[4]),
		.i_session_ended   (src[3]),
		.i_session_ok      (src[2]),
		.i_bus_power_good  (src[1]),
		.i_far_end_detached(src[0]),
		.i_low_power       (i_low_power),
		.i_reg_write       (reg_write),
		.i_reg_read        (reg_read),
		.i_reg_addr        (reg_addr),
		.i_reg_wdata       (reg_wdata),
		.o_reg_rdata       (o_reg_rdata),
		.o_reg_rvalid      (o_reg_rvalid),
		.o_interrupt       (o_interrupt),
		.o_rxcmd_valid     (o_rxcmd_valid),
		.o_rxcmd_status    (o_rxcmd_status)
	);

	link_model link
	(
		.i_clock     (i_clock),
		.i_reg_rdata (o_reg_rdata),
		.i_reg_rvalid(o_reg_rvalid),
		.o_reg_write (reg_write),
		.o_reg_read  (reg_read),
		.o_reg_addr  (reg_addr),
		.o_reg_wdata (reg_wdata)
	);

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		$display("failures=%0d n_compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles >= 20000)
		begin
			failures++;
			end_sim();
		end
	end

	// Changes one source, counts pulses over a settling window
	task automatic move(input logic [2:0] i, input logic v,
		output int n, output logic [4:0] st);
		n  = 0;
		st = 5'h00;
		@(posedge i_clock);
		#1;
		src[i] = v;
		repeat (12)
		begin
			@(posedge i_clock);
			#1;
			if (o_interrupt === 1'b1)
			begin
				n++;
				st = o_rxcmd_status;
				check({7'h00, o_rxcmd_valid}, 8'h01);
			end
		end
	endtask : move

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		int         n;
		logic [4:0] st;
		rows[0] = '{3'd0, 1'b1, 5'h1f, 5'h1f, 2'd1};
		rows[1] = '{3'd0, 1'b0, 5'h1f, 5'h1e, 2'd0};
		rows[2] = '{3'd1, 1'b1, 5'h1d, 5'h1f, 2'd0};
		rows[3] = '{3'd1, 1'b0, 5'h00, 5'h02, 2'd1};
		rows[4] = '{3'd4, 1'b1, 5'h10, 5'h00, 2'd1};
		rows[5] = '{3'd4, 1'b0, 5'h00, 5'h10, 2'd1};
		rows[6] = '{3'd3, 1'b1, 5'h08, 5'h00, 2'd1};
		rows[7] = '{3'd2, 1'b1, 5'h04, 5'h00, 2'd1};
		rows[8] = '{3'd2, 1'b0, 5'h1f, 5'h04, 2'd1};
		rows[9] = '{3'd3, 1'b0, 5'h00, 5'h08, 2'd1};
		repeat (2) @(posedge i_clock);
		#1;
		i_rst = 1'b0;
		for (int a = 13; a <= 18; a++)
		begin
			link.rd(a[5:0], d);
			check(d, 8'h1f);
		end
		link.rd(LATCH_ADDR, d);
		check(d, 8'h00);
		for (int r = 0; r < 10; r++)
		begin
			link.wr(RISE_EN_WRITE_ADDR, {3'h0, rows[r].ren});
			link.wr(FALL_EN_WRITE_ADDR, {3'h0, rows[r].fen});
			move(rows[r].idx, rows[r].lvl, n, st);
			check(n[7:0], {6'h00, rows[r].pulses});
			if (n > 0)
				check({3'h0, st}, {3'h0, src});
			link.rd(LATCH_ADDR, d);
			check(d, rows[r].pulses != 0 ? 8'h01 << rows[r].idx : 8'h00);
			link.rd(STATUS_ADDR, d);
			check(d, {3'h0, src});
		end
		link.wr(RISE_EN_WRITE_ADDR, 8'hff);
		link.rd(RISE_EN_SET_ADDR, d);
		check(d, 8'h1f);
		link.wr(RISE_EN_CLEAR_ADDR, 8'h05);
		link.rd(RISE_EN_WRITE_ADDR, d);
		check(d, 8'h1a);
		link.wr(RISE_EN_SET_ADDR, 8'h01);
		link.rd(RISE_EN_CLEAR_ADDR, d);
		check(d, 8'h1b);
		link.wr(FALL_EN_WRITE_ADDR, 8'h00);
		link.wr(FALL_EN_SET_ADDR, 8'h14);
		link.wr(FALL_EN_CLEAR_ADDR, 8'h04);
		link.rd(FALL_EN_CLEAR_ADDR, d);
		check(d, 8'h10);
		link.wr(FALL_EN_SET_ADDR, 8'h01);
		link.rd(FALL_EN_SET_ADDR, d);
		check(d, 8'h11);
		link.rd(6'h20, d);
		check(d, 8'h00);
		link.wr(STATUS_ADDR, 8'hff);
		link.rd(STATUS_ADDR, d);
		check(d, {3'h0, src});
		move(3'd0, 1'b1, n, st);
		move(3'd1, 1'b1, n, st);
		link.rd(LATCH_ADDR, d);
		check(d, 8'h03);
		link.rd(LATCH_ADDR, d);
		check(d, 8'h00);
		move(3'd0, 1'b0, n, st);
		@(posedge i_clock);
		#1;
		i_low_power = 1'b1;
		@(posedge i_clock);
		#1;
		i_low_power = 1'b0;
		link.rd(LATCH_ADDR, d);
		check(d, 8'h00);
		i_rst = 1'b1;
		repeat (2) @(posedge i_clock);
		#1;
		i_rst = 1'b0;
		link.rd(FALL_EN_WRITE_ADDR, d);
		check(d, 8'h1f);
		end_sim();
	end
endmodule : phy_bus_event_interrupt_bench
